// ---- verilog/frame_check_defs.vh ----
// Purpose: Shared constants of the frame statistics block
// Assumes: Register index = byte address / 4
// Notes: Definitions only
`ifndef FRAME_CHECK_DEFS_VH
`define FRAME_CHECK_DEFS_VH

// Register indices
`define IDX_RX_OVERSIZE_GOOD_HIGH 16'h40A5
`define IDX_RX_OVERSIZE_GOOD_LOW 16'h40A6
`define IDX_RX_UNDERSIZE_GOOD_HIGH 16'h40A7
`define IDX_RX_UNDERSIZE_GOOD_LOW 16'h40A8
`define IDX_RX_CRC_ERROR_COUNT 16'h40A9
`define IDX_RX_OVERSIZE_ERROR_COUNT 16'h40AA
`define IDX_RX_FRAGMENT_COUNT 16'h40AB
`define IDX_RX_MISSING_DELIM_COUNT 16'h40AC
`define IDX_TX_VALID_HIGH 16'h40AD
`define IDX_TX_VALID_LOW 16'h40AE
`define IDX_TX_OVERSIZE_GOOD_HIGH 16'h40AF
`define IDX_TX_OVERSIZE_GOOD_LOW 16'h40B0
`define IDX_TX_UNDERSIZE_GOOD_HIGH 16'h40B1
`define IDX_TX_UNDERSIZE_GOOD_LOW 16'h40B2
`define IDX_TX_CRC_ERROR_COUNT 16'h40B3
`define IDX_TX_OVERSIZE_ERROR_COUNT 16'h40B4
`define IDX_TX_FRAGMENT_COUNT 16'h40B5
`define IDX_TX_MISSING_DELIM_COUNT 16'h40B6
`define IDX_CHECK_CTRL 16'h40F0
`define IDX_IRQ_STATUS 16'h40F1
`define IDX_IRQ_CLEAR 16'h40F2
`define IDX_IRQ_ENABLE 16'h40F3

// Control fields and resets
`define CTRL_CHECKER_ENABLE_BIT 15
`define CTRL_SOURCE_SELECT_BIT 1
`define CTRL_RESET 16'h0000
`define COUNT_RESET 32'h00000000
`define IRQ_BITS 4

// Frame format, lengths count destination address through FCS
`define LEN_MIN 16'h0040
`define LEN_MAX 16'h05EE
`define PREAMBLE_BYTE 8'h55
`define DELIM_BYTE 8'hD5
`define CRC_POLY 32'hEDB88320
`define CRC_INIT 32'hFFFFFFFF
`define CRC_RESIDUE 32'hDEBB20E3

`endif

// ---- verilog/frame_classifier.v ----
// Purpose: Classify one byte-wide frame stream by delimiter, CRC and length
// Assumes: Inputs come from logic on pclk; no synchroniser needed
// Notes: done pulses one cycle; result flags hold and are valid with done
`timescale 1ns/1ns
`include "frame_check_defs.vh"

module frame_classifier (
  input wire pclk,
  input wire presetn,
  input wire enable,
  input wire frame_valid,
  input wire byte_en,
  input wire [7:0] byte_data,
  output reg done,
  output reg crc_good,
  output reg short_frame,
  output reg long_frame,
  output reg no_delim
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PRE = 2'h1;
  localparam [1:0] ST_BODY = 2'h2;
  localparam [1:0] ST_SKIP = 2'h3;

  reg [1:0] state_q;
  reg armed_q;
  reg [15:0] len_q;
  reg [31:0] crc_q;

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  wire starting = (state_q == ST_IDLE);
  wire [1:0] cur = starting ? ST_PRE : state_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      armed_q <= 1'b0;
      len_q <= 16'h0000;
      crc_q <= `CRC_INIT;
      done <= 1'b0;
      crc_good <= 1'b0;
      short_frame <= 1'b0;
      long_frame <= 1'b0;
      no_delim <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        // Disabled: abandon frame, wait for a gap before arming again
        state_q <= ST_IDLE;
        armed_q <= 1'b0;
      end else if (!armed_q) begin
        armed_q <= !frame_valid;
      end else if (frame_valid) begin
        if (starting) begin
          len_q <= 16'h0000;
          crc_q <= `CRC_INIT;
        end
        state_q <= cur;
        if (byte_en) begin
          case (cur)
            ST_PRE: begin
              if (byte_data == `DELIM_BYTE) begin
                state_q <= ST_BODY;
              end else if (byte_data != `PREAMBLE_BYTE) begin
                state_q <= ST_SKIP;
              end
            end
            ST_BODY: begin
              // Preamble and delimiter excluded from length
              if (len_q != 16'hFFFF) begin
                len_q <= len_q + 16'h0001;
              end
              crc_q <= crc_byte(crc_q, byte_data);
            end
            ST_SKIP: begin
              state_q <= ST_SKIP;
            end
            default: begin
              state_q <= ST_IDLE;
            end
          endcase
        end
      end else if (!starting) begin
        done <= 1'b1;
        no_delim <= (state_q != ST_BODY);
        crc_good <= (crc_q == `CRC_RESIDUE);
        short_frame <= (len_q < `LEN_MIN);
        long_frame <= (len_q > `LEN_MAX);
        state_q <= ST_IDLE;
      end
    end
  end
endmodule // frame_classifier

// ---- verilog/frame_check_stats.v ----
// Purpose: Self-test frame statistics counters behind an APB slave
// Assumes: Frame streams are on pclk; register byte address = index * 4
// Notes: Counters clear on read without losing events
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "frame_check_defs.vh"

// Operation
// - Count rx good-CRC frames over 1518 bytes, 32 bits in two halves
// - Count rx good-CRC frames under 64 bytes, 32 bits in two halves
// - Count rx bad-CRC frames of 64 to 1518 bytes, 16 bits
// - Count rx bad-CRC frames over 1518 bytes, 16 bits
// - Count rx frames under 64 bytes that have the start delimiter, any CRC, 16 bits
// - Count rx frames missing the start delimiter, 16 bits
// - Count tx good-CRC frames of 64 to 1518 bytes, 32 bits
// - Count tx good-CRC frames over 1518 bytes, 32 bits
// - Count tx good-CRC frames under 64 bytes, 32 bits
// - Count tx bad-CRC frames of 64 to 1518 bytes, 16 bits
// - Count tx bad-CRC frames over 1518 bytes, 16 bits
// - Count tx frames under 64 bytes that have the start delimiter, any CRC, 16 bits
// - Count tx frames missing the start delimiter, 16 bits
// - Checkers and counters run only while control bit 15 is one
// - Control bit picks generator or MAC data for the tx checker
module frame_check_stats (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire rx_frame_valid,
  input wire rx_byte_en,
  input wire [7:0] rx_byte,
  input wire gen_frame_valid,
  input wire gen_byte_en,
  input wire [7:0] gen_byte,
  input wire mac_frame_valid,
  input wire mac_byte_en,
  input wire [7:0] mac_byte
);
  localparam NUM_CNT = 13;
  // Counters 0,1,6,7,8 are 32 bits wide, the rest 16
  localparam [NUM_CNT-1:0] WIDE = 13'h01C3;

  reg [15:0] ctrl_q;
  reg [`IRQ_BITS-1:0] status_q;
  reg [`IRQ_BITS-1:0] irq_en_q;
  reg [15:0] snap_q;

  wire checker_enable = ctrl_q[`CTRL_CHECKER_ENABLE_BIT];
  wire tx_checker_source_select = ctrl_q[`CTRL_SOURCE_SELECT_BIT];

  // Tx source: 1 selects generator frames, 0 the MAC transmit data
  wire tx_valid_in = tx_checker_source_select ? gen_frame_valid : mac_frame_valid;
  wire tx_en_in = tx_checker_source_select ? gen_byte_en : mac_byte_en;
  wire [7:0] tx_byte_in = tx_checker_source_select ? gen_byte : mac_byte;

  wire r_done, r_good, r_short, r_long, r_nodelim;
  wire t_done, t_good, t_short, t_long, t_nodelim;

  frame_classifier rx_chk (
    .pclk(pclk),
    .presetn(presetn),
    .enable(checker_enable),
    .frame_valid(rx_frame_valid),
    .byte_en(rx_byte_en),
    .byte_data(rx_byte),
    .done(r_done),
    .crc_good(r_good),
    .short_frame(r_short),
    .long_frame(r_long),
    .no_delim(r_nodelim)
  );

  frame_classifier tx_chk (
    .pclk(pclk),
    .presetn(presetn),
    .enable(checker_enable),
    .frame_valid(tx_valid_in),
    .byte_en(tx_en_in),
    .byte_data(tx_byte_in),
    .done(t_done),
    .crc_good(t_good),
    .short_frame(t_short),
    .long_frame(t_long),
    .no_delim(t_nodelim)
  );

  // Frames without a delimiter count only as missing-delimiter
  wire rv = r_done & ~r_nodelim;
  wire tv = t_done & ~t_nodelim;
  wire r_mid = ~r_short & ~r_long;
  wire t_mid = ~t_short & ~t_long;

  wire [NUM_CNT-1:0] inc;
  assign inc[0] = rv & r_good & r_long;
  assign inc[1] = rv & r_good & r_short;
  assign inc[2] = rv & ~r_good & r_mid;
  assign inc[3] = rv & ~r_good & r_long;
  assign inc[4] = rv & r_short;
  assign inc[5] = r_done & r_nodelim;
  assign inc[6] = tv & t_good & t_mid;
  assign inc[7] = tv & t_good & t_long;
  assign inc[8] = tv & t_good & t_short;
  assign inc[9] = tv & ~t_good & t_mid;
  assign inc[10] = tv & ~t_good & t_long;
  assign inc[11] = tv & t_short;
  assign inc[12] = t_done & t_nodelim;

  // Address decode
  wire [15:0] idx = paddr[17:2];
  reg [3:0] m_cnt;
  reg m_hi;
  reg m_hit_cnt;
  reg m_hit_reg;

  always @* begin
    m_cnt = 4'h0;
    m_hi = 1'b0;
    m_hit_cnt = 1'b1;
    m_hit_reg = 1'b0;
    case (idx)
      `IDX_RX_OVERSIZE_GOOD_HIGH: begin
        m_cnt = 4'h0;
        m_hi = 1'b1;
      end
      `IDX_RX_OVERSIZE_GOOD_LOW: m_cnt = 4'h0;
      `IDX_RX_UNDERSIZE_GOOD_HIGH: begin
        m_cnt = 4'h1;
        m_hi = 1'b1;
      end
      `IDX_RX_UNDERSIZE_GOOD_LOW: m_cnt = 4'h1;
      `IDX_RX_CRC_ERROR_COUNT: m_cnt = 4'h2;
      `IDX_RX_OVERSIZE_ERROR_COUNT: m_cnt = 4'h3;
      `IDX_RX_FRAGMENT_COUNT: m_cnt = 4'h4;
      `IDX_RX_MISSING_DELIM_COUNT: m_cnt = 4'h5;
      `IDX_TX_VALID_HIGH: begin
        m_cnt = 4'h6;
        m_hi = 1'b1;
      end
      `IDX_TX_VALID_LOW: m_cnt = 4'h6;
      `IDX_TX_OVERSIZE_GOOD_HIGH: begin
        m_cnt = 4'h7;
        m_hi = 1'b1;
      end
      `IDX_TX_OVERSIZE_GOOD_LOW: m_cnt = 4'h7;
      `IDX_TX_UNDERSIZE_GOOD_HIGH: begin
        m_cnt = 4'h8;
        m_hi = 1'b1;
      end
      `IDX_TX_UNDERSIZE_GOOD_LOW: m_cnt = 4'h8;
      `IDX_TX_CRC_ERROR_COUNT: m_cnt = 4'h9;
      `IDX_TX_OVERSIZE_ERROR_COUNT: m_cnt = 4'hA;
      `IDX_TX_FRAGMENT_COUNT: m_cnt = 4'hB;
      `IDX_TX_MISSING_DELIM_COUNT: m_cnt = 4'hC;
      `IDX_CHECK_CTRL, `IDX_IRQ_STATUS, `IDX_IRQ_CLEAR, `IDX_IRQ_ENABLE: begin
        m_hit_cnt = 1'b0;
        m_hit_reg = 1'b1;
      end
      default: m_hit_cnt = 1'b0;
    endcase
  end

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire rd_take = access & ~pwrite & m_hit_cnt;
  wire wr_take = access & pwrite;

  // Counter bank
  wire [NUM_CNT*32-1:0] cnt_flat;
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g = g + 1) begin : cnt_gen
      reg [31:0] val_q;
      wire clr = rd_take & ({28'h0000000, m_cnt} == g);
      // Subtract the value shown, so events after the snapshot survive
      wire [15:0] hi_clr = val_q[31:16] - snap_q;
      wire [15:0] lo_clr = val_q[15:0] - snap_q;
      wire [31:0] base = !clr ? val_q : (m_hi ? {hi_clr, val_q[15:0]} : {val_q[31:16], lo_clr});
      wire [31:0] mask = WIDE[g] ? 32'hFFFFFFFF : 32'h0000FFFF;
      wire [31:0] val_d = (base + {31'h00000000, inc[g]}) & mask;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_q <= `COUNT_RESET;
        end else begin
          val_q <= val_d;
        end
      end
      assign cnt_flat[g*32 +: 32] = val_q;
    end
  endgenerate

  // Named views of the counter bank
  wire [31:0] rx_oversize_good_count = cnt_flat[31:0];
  wire [31:0] rx_undersize_good_count = cnt_flat[63:32];
  wire [15:0] rx_crc_error_tally = cnt_flat[79:64];
  wire [15:0] rx_oversize_error_tally = cnt_flat[111:96];
  wire [15:0] rx_fragment_tally = cnt_flat[143:128];
  wire [15:0] rx_missing_delim_tally = cnt_flat[175:160];
  wire [31:0] tx_valid_count = cnt_flat[223:192];
  wire [31:0] tx_oversize_good_count = cnt_flat[255:224];
  wire [31:0] tx_undersize_good_count = cnt_flat[287:256];
  wire [15:0] tx_crc_error_tally = cnt_flat[303:288];
  wire [15:0] tx_oversize_error_tally = cnt_flat[335:320];
  wire [15:0] tx_fragment_tally = cnt_flat[367:352];
  wire [15:0] tx_missing_delim_tally = cnt_flat[399:384];

  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (idx)
      `IDX_RX_OVERSIZE_GOOD_HIGH: rd_val = {16'h0000, rx_oversize_good_count[31:16]};
      `IDX_RX_OVERSIZE_GOOD_LOW: rd_val = {16'h0000, rx_oversize_good_count[15:0]};
      `IDX_RX_UNDERSIZE_GOOD_HIGH: rd_val = {16'h0000, rx_undersize_good_count[31:16]};
      `IDX_RX_UNDERSIZE_GOOD_LOW: rd_val = {16'h0000, rx_undersize_good_count[15:0]};
      `IDX_RX_CRC_ERROR_COUNT: rd_val = {16'h0000, rx_crc_error_tally};
      `IDX_RX_OVERSIZE_ERROR_COUNT: rd_val = {16'h0000, rx_oversize_error_tally};
      `IDX_RX_FRAGMENT_COUNT: rd_val = {16'h0000, rx_fragment_tally};
      `IDX_RX_MISSING_DELIM_COUNT: rd_val = {16'h0000, rx_missing_delim_tally};
      `IDX_TX_VALID_HIGH: rd_val = {16'h0000, tx_valid_count[31:16]};
      `IDX_TX_VALID_LOW: rd_val = {16'h0000, tx_valid_count[15:0]};
      `IDX_TX_OVERSIZE_GOOD_HIGH: rd_val = {16'h0000, tx_oversize_good_count[31:16]};
      `IDX_TX_OVERSIZE_GOOD_LOW: rd_val = {16'h0000, tx_oversize_good_count[15:0]};
      `IDX_TX_UNDERSIZE_GOOD_HIGH: rd_val = {16'h0000, tx_undersize_good_count[31:16]};
      `IDX_TX_UNDERSIZE_GOOD_LOW: rd_val = {16'h0000, tx_undersize_good_count[15:0]};
      `IDX_TX_CRC_ERROR_COUNT: rd_val = {16'h0000, tx_crc_error_tally};
      `IDX_TX_OVERSIZE_ERROR_COUNT: rd_val = {16'h0000, tx_oversize_error_tally};
      `IDX_TX_FRAGMENT_COUNT: rd_val = {16'h0000, tx_fragment_tally};
      `IDX_TX_MISSING_DELIM_COUNT: rd_val = {16'h0000, tx_missing_delim_tally};
      `IDX_CHECK_CTRL: rd_val = {16'h0000, ctrl_q};
      `IDX_IRQ_STATUS: rd_val = {28'h0000000, status_q};
      `IDX_IRQ_CLEAR: rd_val = 32'h00000000;
      `IDX_IRQ_ENABLE: rd_val = {28'h0000000, irq_en_q};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Events: 0 rx frame, 1 tx frame, 2 rx error, 3 tx error
  wire rx_frame_event = r_done;
  wire tx_frame_event = t_done;
  wire rx_error_event = r_done & (r_nodelim | ~r_good);
  wire tx_error_event = t_done & (t_nodelim | ~t_good);
  wire [`IRQ_BITS-1:0] ev = {tx_error_event, rx_error_event, tx_frame_event, rx_frame_event};
  wire [`IRQ_BITS-1:0] clr_bits = (wr_take && idx == `IDX_IRQ_CLEAR) ?
                                  pwdata[`IRQ_BITS-1:0] : 4'h0;

  reg [15:0] ctrl_d;
  reg [`IRQ_BITS-1:0] irq_en_d;
  reg [`IRQ_BITS-1:0] status_d;
  always @* begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    if (wr_take && idx == `IDX_CHECK_CTRL) begin
      ctrl_d = pwdata[15:0];
    end
    if (wr_take && idx == `IDX_IRQ_ENABLE) begin
      irq_en_d = pwdata[`IRQ_BITS-1:0];
    end
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~clr_bits) | ev;
  end

  // Bus slave: answer prepared in setup, pready high for the one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      snap_q <= 16'h0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~(m_hit_cnt | m_hit_reg);
      if (setup && !pwrite) begin
        prdata <= rd_val;
        // Shown half kept so the clear spares events that arrive meanwhile
        snap_q <= rd_val[15:0];
      end
    end
  end

  // Control, enable and sticky status; irq trails status by one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      irq_en_q <= 4'h0;
      status_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      status_q <= status_d;
      irq <= |(status_q & irq_en_q);
    end
  end
endmodule // frame_check_stats

// ---- tb/frame_check_stats_sva.sv ----
// Purpose: Port checks of the frame statistics block
// Assumes: Zero-wait APB, index is paddr[17:2]
// Notes: Clear-on-read check needs quiet streams
`timescale 1ns/1ns
module frame_check_stats_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire irq,
  input wire rx_frame_valid,
  input wire gen_frame_valid,
  input wire mac_frame_valid
);
  wire [15:0] idx = paddr[17:2];
  wire setup = psel && !penable;
  wire wr_done = psel && penable && pready && pwrite;
  wire is_cnt = idx >= 16'h40A5 && idx <= 16'h40B6;
  wire mapped = is_cnt || (idx >= 16'h40F0 && idx <= 16'h40F3);
  wire [2:0] fv = {rx_frame_valid, gen_frame_valid, mac_frame_valid};
  reg [2:0] fv_q;
  reg [3:0] idle_q;
  wire end_any = |(fv_q & ~fv);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fv_q <= 3'h0;
      idle_q <= 4'h0;
    end else begin
      fv_q <= fv;
      idle_q <= (|fv) ? 4'h0 : ((idle_q == 4'hF) ? idle_q : idle_q + 4'h1);
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (setup && !mapped && !pwrite |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_read_clears: assert property (setup && !pwrite && is_cnt ##3 setup && !pwrite
    && idle_q > 4'h8 && paddr == $past(paddr, 3) |=> prdata == 32'h0)
    else $error("counter not cleared by read");
  a_half_width: assert property (pready && !pwrite && is_cnt |-> prdata[31:16] == 16'h0)
    else $error("counter half wider than 16 bits");
  a_irq_cause: assert property ($rose(irq) |-> $past(end_any, 3) || $past(wr_done, 2))
    else $error("irq rose without cause");
  a_rdata_hold: assert property (!(setup && !pwrite) |=> $stable(prdata))
    else $error("read data changed outside read setup");
endmodule // frame_check_stats_sva

bind frame_check_stats frame_check_stats_sva frame_check_stats_sva_inst (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq(irq),
  .rx_frame_valid(rx_frame_valid),
  .gen_frame_valid(gen_frame_valid),
  .mac_frame_valid(mac_frame_valid)
);

// ---- tb/frame_source.sv ----
// Purpose: Byte-stream frame source for wire, generator or MAC side
// Assumes: One byte per clock within a frame
// Notes: Idle data inverted so stale bytes never look valid
`timescale 1ns/1ns
`include "frame_check_defs.vh"
module frame_source (
  input wire pclk,
  output reg frame_valid,
  output reg byte_en,
  output reg [7:0] byte_out
);
  reg [31:0] crc = 32'hFFFFFFFF;
  initial begin
    frame_valid = 1'b0;
    byte_en = 1'b0;
    byte_out = 8'h00;
  end
  task put(input [7:0] b);
    @(posedge pclk);
    frame_valid <= 1'b1;
    byte_en <= 1'b1;
    byte_out <= b;
    for (int i = 0; i < 8; i++)
      crc = (crc[0] ^ b[i]) ? (crc >> 1) ^ `CRC_POLY : crc >> 1;
  endtask
  task send(input int len, input bit bad, input bit nodelim);
    reg [31:0] fcs;
    for (int k = 0; k < 7; k++)
      put(`PREAMBLE_BYTE);
    put(nodelim ? 8'h5A : `DELIM_BYTE);
    crc = `CRC_INIT;
    for (int k = 0; k < len - 4; k++)
      put(k[7:0]);
    fcs = ~crc ^ {31'h0, bad};
    for (int k = 0; k < 4; k++)
      put(fcs[8 * k +: 8]);
    @(posedge pclk);
    frame_valid <= 1'b0;
    byte_en <= 1'b0;
    byte_out <= ~byte_out;
    @(posedge pclk);
  endtask
  // Length boundaries on both sides of 64 and 1518
  task burst;
    send(64, 1'b0, 1'b0);
    send(1518, 1'b0, 1'b0);
    send(1519, 1'b0, 1'b0);
    send(63, 1'b0, 1'b0);
    send(64, 1'b1, 1'b0);
    send(1518, 1'b1, 1'b0);
    send(1519, 1'b1, 1'b0);
    send(63, 1'b1, 1'b0);
    send(64, 1'b0, 1'b1);
  endtask
endmodule // frame_source

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the frame statistics block
// Assumes: APB master tasks, three frame sources
// Notes: Long frames dominate run time
`timescale 1ns/1ns
`include "frame_check_defs.vh"
module tb_top;
  // Expected count per counter after one burst, two bits each
  localparam [35:0] EXP = 36'h664486644;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [17:0] paddr = 18'h00000;
  reg [31:0] pwdata = 32'h00000000;
  wire [31:0] prdata;
  wire pready, pslverr, irq, rx_fv, rx_en, gen_fv, gen_en, mac_fv, mac_en;
  wire [7:0] rx_b, gen_b, mac_b;
  reg [31:0] rdv;
  reg erv;
  int n_errors = 0;
  int checked = 0;
  always #25 pclk = ~pclk;
  frame_source rx_src (.pclk(pclk), .frame_valid(rx_fv), .byte_en(rx_en), .byte_out(rx_b));
  frame_source gen_src (.pclk(pclk), .frame_valid(gen_fv), .byte_en(gen_en), .byte_out(gen_b));
  frame_source mac_src (.pclk(pclk), .frame_valid(mac_fv), .byte_en(mac_en), .byte_out(mac_b));
  frame_check_stats frame_check_stats_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .rx_frame_valid(rx_fv),
    .rx_byte_en(rx_en), .rx_byte(rx_b), .gen_frame_valid(gen_fv), .gen_byte_en(gen_en),
    .gen_byte(gen_b), .mac_frame_valid(mac_fv), .mac_byte_en(mac_en), .mac_byte(mac_b));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input bit w, input [15:0] idx, input [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input [15:0] idx, input [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask
  task wr(input [15:0] idx, input [31:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task irq_is(input bit exp);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge pclk);
  endtask
  task sweep(input bit zero);
    reg [31:0] e;
    for (int k = 0; k < 18; k++) begin
      e = zero ? 32'h0 : {30'h0, EXP[2 * k +: 2]};
      rd(16'h40A5 + k[15:0], e);
      rd(16'h40A5 + k[15:0], 32'h0);
    end
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #3000000;
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sweep(1'b1);
    irq_is(1'b0);
    apb(1'b0, 16'h4000, 32'h0);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    $display("test reset done");
    fork
      rx_src.burst;
      mac_src.burst;
    join
    sweep(1'b1);
    rd(`IDX_IRQ_STATUS, 32'h0);
    $display("test disabled done");
    fork
      rx_src.send(1519, 1'b0, 1'b0);
      begin
        repeat (100) @(posedge pclk);
        wr(`IDX_CHECK_CTRL, 32'h8000);
      end
    join
    wr(`IDX_IRQ_ENABLE, 32'hF);
    fork
      rx_src.burst;
      mac_src.burst;
    join
    rd(`IDX_IRQ_STATUS, 32'hF);
    irq_is(1'b1);
    wr(`IDX_IRQ_ENABLE, 32'h0);
    irq_is(1'b0);
    wr(`IDX_IRQ_CLEAR, 32'hF);
    rd(`IDX_IRQ_STATUS, 32'h0);
    wr(`IDX_IRQ_ENABLE, 32'hF);
    irq_is(1'b0);
    sweep(1'b0);
    $display("test counters done");
    wr(`IDX_CHECK_CTRL, 32'h8002);
    rd(`IDX_CHECK_CTRL, 32'h8002);
    fork
      rx_src.burst;
      gen_src.burst;
      mac_src.send(1519, 1'b1, 1'b0);
    join
    sweep(1'b0);
    $display("test source select done");
    wrap_up;
  end
endmodule // tb_top
